// ### src/lcdrc_pkg.sv
// constants shared by the lcd refresh, cursor and gray-scale engine
package lcdrc_pkg;

    // ====
    // register byte offsets on the avalon slave
    localparam logic [5:0] OFS_START = 6'h00;
    localparam logic [5:0] OFS_VPAGE = 6'h04;
    localparam logic [5:0] OFS_WIDTH = 6'h08;
    localparam logic [5:0] OFS_HEIGHT = 6'h0C;
    localparam logic [5:0] OFS_CUR_X = 6'h10;
    localparam logic [5:0] OFS_CUR_Y = 6'h14;
    localparam logic [5:0] OFS_CUR_WH = 6'h18;
    localparam logic [5:0] OFS_BLINK = 6'h1C;
    localparam logic [5:0] OFS_MODE = 6'h20;
    localparam logic [5:0] OFS_PALETTE = 6'h24;
    localparam logic [5:0] OFS_FRC = 6'h28;
    localparam logic [5:0] OFS_CLOCKING = 6'h2C;
    localparam logic [5:0] OFS_STATUS = 6'h30;

    // ====
    // reset values
    localparam logic [28:0] RST_START = 29'h0000_0000;
    localparam logic [7:0] RST_VPAGE = 8'hFF;
    localparam logic [9:0] RST_WIDTH = 10'h03F0;
    localparam logic [8:0] RST_HEIGHT = 9'h01FF;
    localparam logic [15:0] RST_CUR_X = 16'h0000;
    localparam logic [8:0] RST_CUR_Y = 9'h0000;
    localparam logic [15:0] RST_CUR_WH = 16'h0101;
    localparam logic [7:0] RST_BLINK = 8'h7F;
    localparam logic [15:0] RST_PALETTE = 16'hF730;
    localparam logic [7:0] RST_FRC = 8'h73;
    localparam logic [7:0] RST_CLOCKING = 8'h02;

    // ====
    // field positions
    localparam int CUR_STYLE_LSB = 14;
    localparam int CUR_W_LSB = 8;
    localparam int BLINK_EN_BIT = 7;
    localparam int FRC_Y_LSB = 4;
    localparam int CLK_ON_BIT = 7;

    // cursor style codes
    localparam logic [1:0] CUR_OFF = 2'h0;
    localparam logic [1:0] CUR_BLACK = 2'h1;
    localparam logic [1:0] CUR_INVERT = 2'h2;
    localparam logic [1:0] CUR_WHITE = 2'h3;

    // screen limits in pixels
    localparam int MAX_BW_W = 640;
    localparam int MAX_BW_H = 512;
    localparam int MAX_GRAY_W = 320;
    localparam int MAX_GRAY_H = 240;

    // dma sequencer states
    typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_XFER} lcdrc_dma_t;

endpackage

// ### src/lcdrc_engine.sv
// lcd refresh engine: dma fetch, scan counters, cursor and gray modulation
`timescale 1ns/10ps

// What this block does
// - supports up to 640x512 black/white and 320x240 gray panels
// - each frame scans from the start address over programmed width, height
// - virtual page height is not used by scan or fetch logic
// - x and y counters locate the pixel; cursor window alters it
// - cursor window shows transparent, black, reversed, white or blinking
// - style code 00 off, 01 black, 10 reversed, 11 white
// - blinking alternates original and cursor at divisor-set speed
// - blink toggles once every divisor plus one frame pulses
// - one bit per pixel mode drives each pixel fully on or off
// - two bit mode uses frame rate control for gray tones
// - gray code 0 gives zero, 1 one eighth, n gives (n+1)/16
// - pixel value 0 is white and 1 is black
// - gray level per pixel value comes from the palette register
// - horizontal and vertical offsets stagger the modulation pattern
// - clearing the on bit stops pixels before next fill, then halts
// - setting the on bit resumes dma and refresh synchronously
// - fetch raises bus request, waits grant, bursts words into buffer
// - fly-by 16-bit burst fetches spread evenly over the frame
// - refresh runs continuously at 50 to 70 hz
// - each transfer lasts a programmable number of dma clocks
module lcdrc_engine
#(
    parameter int LINE_WORDS = 64,
    parameter int ADDR_W = 29
)
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // system bus master for fly-by fetches
    output logic bus_request,
    input wire logic bus_grant,
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_read,
    input wire logic [15:0] mem_rdata,
    // pixel clock from the panel side
    input wire logic pixel_clk_in,
    // pixel stream
    output logic lcd_pixel,
    output logic lcd_pixel_strobe,
    output logic lcd_line_pulse,
    output logic lcd_frame_mark
);
    import lcdrc_pkg::*;

    localparam int IDX_W = $clog2(LINE_WORDS);

    // ====
    // registers
    logic [28:0] screen_start_address_r;
    logic [7:0] virtual_page_width_r;
    logic [9:0] screen_width_setting_r;
    logic [8:0] screen_height_setting_r;
    logic [15:0] cur_x_r;
    logic [8:0] cur_y_r;
    logic [15:0] cur_wh_r;
    logic [7:0] blink_control_reg_r;
    logic [1:0] mode_r;
    logic [15:0] gray_palette_map_r;
    logic [7:0] frame_modulation_control_r;
    logic [7:0] display_clocking_control_r;
    logic [15:0] virtual_page_height_r;
    logic avs_waitrequest_r;
    logic [31:0] avs_readdata_r;

    // ====
    // pixel clock sampling and scan state
    logic pclk_s1_r, pclk_s2_r, pclk_s3_r, pclk_lvl_r;
    logic [9:0] horizontal_pixel_counter;
    logic [8:0] vertical_line_counter;
    logic [3:0] frame_cnt_r;
    logic [6:0] blink_cnt_r;
    logic blink_phase_r;
    logic running_r;
    logic disp_bank_r;
    logic [1:0] bank_full_r;

    // dma state
    lcdrc_dma_t dma_state_r;
    logic fill_bank_r;
    logic [IDX_W-1:0] word_idx_r;
    logic [7:0] tick_r;
    logic [ADDR_W-1:0] line_addr_r;
    logic [ADDR_W-1:0] mem_addr_r;
    logic [8:0] fetch_y_r;
    logic bus_request_r, mem_read_r;
    logic [15:0] line_mem [0:2*LINE_WORDS-1];

    // ====
    // bus decode: answer one cycle after a request is seen
    wire bus_req = avs_read | avs_write;
    wire wr_commit = avs_write & ~avs_waitrequest_r;
    wire gray_mode = mode_r != 2'h0;
    wire ctrl_on = display_clocking_control_r[CLK_ON_BIT];
    wire [7:0] clks_per_xfer = {1'b0, display_clocking_control_r[6:0]};
    logic [31:0] rd_mux;

    always_comb
    begin
        case (avs_address)
            OFS_START: rd_mux = {3'h0, screen_start_address_r};
            OFS_VPAGE: rd_mux = {virtual_page_height_r, 8'h00,
                                 virtual_page_width_r};
            OFS_WIDTH: rd_mux = {22'h00_0000, screen_width_setting_r};
            OFS_HEIGHT: rd_mux = {23'h00_0000, screen_height_setting_r};
            OFS_CUR_X: rd_mux = {16'h0000, cur_x_r};
            OFS_CUR_Y: rd_mux = {23'h00_0000, cur_y_r};
            OFS_CUR_WH: rd_mux = {16'h0000, cur_wh_r};
            OFS_BLINK: rd_mux = {24'h00_0000, blink_control_reg_r};
            OFS_MODE: rd_mux = {30'h0000_0000, mode_r};
            OFS_PALETTE: rd_mux = {16'h0000, gray_palette_map_r};
            OFS_FRC: rd_mux = {24'h00_0000, frame_modulation_control_r};
            OFS_CLOCKING: rd_mux = {24'h00_0000, display_clocking_control_r};
            OFS_STATUS: rd_mux = {running_r, blink_phase_r, 1'b0,
                                  vertical_line_counter, 10'h000,
                                  horizontal_pixel_counter};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            avs_waitrequest_r <= 1'b1;
            avs_readdata_r <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            avs_waitrequest_r <= ~(bus_req & avs_waitrequest_r);
            if (bus_req & avs_waitrequest_r)
                avs_readdata_r <= rd_mux;
        end
    end

    // register writes land on the edge that completes the request
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            screen_start_address_r <= RST_START;
            virtual_page_width_r <= RST_VPAGE;
            virtual_page_height_r <= 16'h0000;
            screen_width_setting_r <= RST_WIDTH;
            screen_height_setting_r <= RST_HEIGHT;
            cur_x_r <= RST_CUR_X;
            cur_y_r <= RST_CUR_Y;
            cur_wh_r <= RST_CUR_WH;
            blink_control_reg_r <= RST_BLINK;
            mode_r <= 2'h0;
            gray_palette_map_r <= RST_PALETTE;
            frame_modulation_control_r <= RST_FRC;
            display_clocking_control_r <= RST_CLOCKING;
        end
        else if (clk_en & wr_commit)
        begin
            case (avs_address)
                OFS_START: screen_start_address_r <= avs_writedata[28:0];
                OFS_VPAGE:
                begin
                    virtual_page_width_r <= avs_writedata[7:0];
                    // stored for software only, never read by scan
                    virtual_page_height_r <= avs_writedata[31:16];
                end
                OFS_WIDTH: screen_width_setting_r <= {avs_writedata[9:4],
                                                      4'h0};
                OFS_HEIGHT: screen_height_setting_r <= avs_writedata[8:0];
                OFS_CUR_X: cur_x_r <= avs_writedata[15:0];
                OFS_CUR_Y: cur_y_r <= avs_writedata[8:0];
                OFS_CUR_WH: cur_wh_r <= avs_writedata[15:0];
                OFS_BLINK: blink_control_reg_r <= avs_writedata[7:0];
                OFS_MODE: mode_r <= avs_writedata[1:0];
                OFS_PALETTE: gray_palette_map_r <= avs_writedata[15:0];
                OFS_FRC: frame_modulation_control_r <= avs_writedata[7:0];
                OFS_CLOCKING: display_clocking_control_r <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ====
    // pixel clock: three flops, level moves when the last two agree
    wire pclk_rise = pclk_s2_r & pclk_s3_r & ~pclk_lvl_r;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pclk_s1_r <= 1'b0;
            pclk_s2_r <= 1'b0;
            pclk_s3_r <= 1'b0;
            pclk_lvl_r <= 1'b0;
        end
        else if (clk_en)
        begin
            pclk_s1_r <= pixel_clk_in;
            pclk_s2_r <= pclk_s1_r;
            pclk_s3_r <= pclk_s2_r;
            if (pclk_s2_r == pclk_s3_r)
                pclk_lvl_r <= pclk_s3_r;
        end
    end

    // ====
    // line words: 16 pixels per word in b/w, 8 in gray
    wire [6:0] words_per_line = gray_mode
        ? screen_width_setting_r[9:3] : {1'b0, screen_width_setting_r[9:4]};
    wire [ADDR_W-1:0] page_bytes = {{(ADDR_W-9){1'b0}},
                                    virtual_page_width_r, 1'b0};
    wire last_word = word_idx_r == IDX_W'(words_per_line - 7'd1);
    wire last_tick = tick_r + 8'd1 >= clks_per_xfer;
    wire last_fetch_line = fetch_y_r == screen_height_setting_r;
    // fetch only while on; a stopped engine starts no new fill
    wire fetch_start = ctrl_on & running_r & ~bank_full_r[fill_bank_r];

    // request, grant, then a fly-by burst of word reads
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            dma_state_r <= DMA_IDLE;
            bus_request_r <= 1'b0;
            mem_read_r <= 1'b0;
            mem_addr_r <= '0;
            word_idx_r <= '0;
            tick_r <= 8'h00;
        end
        else if (clk_en)
        begin
            case (dma_state_r)
                DMA_IDLE:
                    if (fetch_start)
                    begin
                        bus_request_r <= 1'b1;
                        mem_addr_r <= line_addr_r;
                        dma_state_r <= DMA_REQ;
                    end
                DMA_REQ:
                    if (bus_grant)
                    begin
                        mem_read_r <= 1'b1;
                        word_idx_r <= '0;
                        tick_r <= 8'h00;
                        dma_state_r <= DMA_XFER;
                    end
                DMA_XFER:
                    // each word held for the programmed clock count
                    if (last_tick)
                    begin
                        tick_r <= 8'h00;
                        mem_addr_r <= mem_addr_r + ADDR_W'(2);
                        word_idx_r <= word_idx_r + IDX_W'(1);
                        if (last_word)
                        begin
                            bus_request_r <= 1'b0;
                            mem_read_r <= 1'b0;
                            dma_state_r <= DMA_IDLE;
                        end
                    end
                    else
                        tick_r <= tick_r + 8'h01;
                default: dma_state_r <= DMA_IDLE;
            endcase
        end
    end

    wire xfer_done = dma_state_r == DMA_XFER && last_tick && last_word;

    // capture words, step line address; frame wraps to start
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            fill_bank_r <= 1'b0;
            fetch_y_r <= 9'h000;
            line_addr_r <= '0;
        end
        else if (clk_en)
        begin
            if (dma_state_r == DMA_XFER && last_tick)
                line_mem[{fill_bank_r, word_idx_r}] <= mem_rdata;
            if (!running_r)
            begin
                fill_bank_r <= 1'b0;
                fetch_y_r <= 9'h000;
                line_addr_r <= ADDR_W'(screen_start_address_r);
            end
            else if (xfer_done)
            begin
                fill_bank_r <= ~fill_bank_r;
                fetch_y_r <= last_fetch_line ? 9'h000 : fetch_y_r + 9'h001;
                line_addr_r <= last_fetch_line
                             ? ADDR_W'(screen_start_address_r)
                             : line_addr_r + page_bytes;
            end
        end
    end

    // ====
    // pixel fetch from the display bank
    wire [9:0] px = horizontal_pixel_counter;
    wire [8:0] py = vertical_line_counter;
    wire [IDX_W-1:0] rd_idx = gray_mode ? IDX_W'(px[9:3]) : IDX_W'(px[9:4]);
    wire [15:0] rd_word = line_mem[{disp_bank_r, rd_idx}];
    wire bw_bit = rd_word[4'hF - px[3:0]];
    wire [1:0] gray_val = rd_word[5'd15 - {1'b0, px[2:0], 1'b0} -: 2];

    // palette lookup and density in sixteenths
    wire [3:0] gray_code = gray_palette_map_r[{gray_val, 2'b00} +: 4];
    wire [4:0] density = gray_code == 4'h0 ? 5'd0
                       : gray_code == 4'h1 ? 5'd2
                       : {1'b0, gray_code} + 5'd1;
    // offsets stagger the per-pixel phase of the pattern
    wire [7:0] x_term = px[3:0] * frame_modulation_control_r[3:0];
    wire [7:0] y_term = py[3:0] * frame_modulation_control_r[7:FRC_Y_LSB];
    wire [3:0] frc_phase = frame_cnt_r + x_term[3:0] + y_term[3:0];
    // 1 is black, 0 is white on the panel
    wire frc_on = {1'b0, frc_phase} < density;
    wire base_pix = gray_mode ? frc_on : bw_bit;

    // cursor window and style
    wire [1:0] cur_style = cur_x_r[CUR_STYLE_LSB +: 2];
    wire [9:0] cur_x0 = cur_x_r[9:0];
    wire [4:0] cur_w = cur_wh_r[CUR_W_LSB +: 5];
    wire [4:0] cur_h = cur_wh_r[4:0];
    wire in_cursor = cur_w != 5'h0 && cur_h != 5'h0
                   && px >= cur_x0 && px < cur_x0 + {5'h00, cur_w}
                   && py >= cur_y_r && py < cur_y_r + {4'h0, cur_h};
    wire blink_en = blink_control_reg_r[BLINK_EN_BIT];
    // blinking shows the plain pixel in the off half-period
    wire show_cursor = in_cursor && !(blink_en && !blink_phase_r);
    logic out_pix;

    always_comb
    begin
        case (cur_style)
            CUR_BLACK: out_pix = show_cursor ? 1'b1 : base_pix;
            CUR_INVERT: out_pix = show_cursor ? ~base_pix : base_pix;
            CUR_WHITE: out_pix = show_cursor ? 1'b0 : base_pix;
            default: out_pix = base_pix;
        endcase
    end

    // ====
    // scan counters; one pixel per pixel clock, sets the frame rate
    wire line_end = px == screen_width_setting_r - 10'd1;
    wire frame_end = line_end && py == screen_height_setting_r;
    wire step = pclk_rise & running_r & bank_full_r[disp_bank_r];

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            horizontal_pixel_counter <= 10'h000;
            vertical_line_counter <= 9'h000;
            disp_bank_r <= 1'b0;
            bank_full_r <= 2'b00;
            running_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // a finished fill marks its bank; display frees the other
            if (xfer_done)
                bank_full_r[fill_bank_r] <= 1'b1;
            if (!running_r)
            begin
                // restart from a clean frame when turned back on
                running_r <= ctrl_on;
                horizontal_pixel_counter <= 10'h000;
                vertical_line_counter <= 9'h000;
                disp_bank_r <= 1'b0;
                bank_full_r <= 2'b00;
            end
            else if (step)
            begin
                horizontal_pixel_counter <= line_end ? 10'h000
                                          : px + 10'd1;
                if (line_end)
                begin
                    vertical_line_counter <= frame_end ? 9'h000
                                           : py + 9'd1;
                    bank_full_r[disp_bank_r] <= 1'b0;
                    disp_bank_r <= ~disp_bank_r;
                    // halt at a line boundary, before the next fill
                    if (!ctrl_on)
                        running_r <= 1'b0;
                end
            end
            else if (!ctrl_on && dma_state_r == DMA_IDLE
                     && !bank_full_r[disp_bank_r])
                running_r <= 1'b0;
        end
    end

    // frame count for modulation and blink divider
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            frame_cnt_r <= 4'h0;
            blink_cnt_r <= 7'h00;
            blink_phase_r <= 1'b0;
        end
        else if (clk_en && step && frame_end)
        begin
            frame_cnt_r <= frame_cnt_r + 4'h1;
            if (blink_cnt_r >= blink_control_reg_r[6:0])
            begin
                blink_cnt_r <= 7'h00;
                blink_phase_r <= ~blink_phase_r;
            end
            else
                blink_cnt_r <= blink_cnt_r + 7'h01;
        end
    end

    // output flops: pixel with strobe, line and frame markers
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            lcd_pixel <= 1'b0;
            lcd_pixel_strobe <= 1'b0;
            lcd_line_pulse <= 1'b0;
            lcd_frame_mark <= 1'b0;
        end
        else if (clk_en)
        begin
            lcd_pixel_strobe <= step;
            lcd_line_pulse <= step & line_end;
            lcd_frame_mark <= step & px == 10'h000 & py == 9'h000;
            if (step)
                lcd_pixel <= out_pix;
        end
    end

    assign avs_readdata = avs_readdata_r;
    assign avs_waitrequest = avs_waitrequest_r;
    assign bus_request = bus_request_r;
    assign mem_addr = mem_addr_r;
    assign mem_read = mem_read_r;

endmodule

// ### verification/lcdrc_chk.sv
// port assertions for the lcd refresh engine
`timescale 1ns/10ps
module lcdrc_chk
#(
    parameter int ADDR_W = 29
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // fetch bus
    input wire logic bus_request,
    input wire logic bus_grant,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_read,
    // pixel stream
    input wire logic lcd_pixel_strobe,
    input wire logic lcd_line_pulse,
    input wire logic lcd_frame_mark
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ====
    // register answers in one cycle, fetch handshake and word order
    property p_wait_ans;
        (avs_read || avs_write) && avs_waitrequest
            |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans)
        else $error("register answer not one cycle");
    property p_grant_rd; $rose(mem_read) |-> $past(bus_grant); endproperty
    a_grant_rd: assert property (p_grant_rd)
        else $error("read burst before grant");
    property p_rd_req; mem_read |-> bus_request; endproperty
    a_rd_req: assert property (p_rd_req)
        else $error("read without bus request");
    property p_drop; $fell(bus_request) |-> $fell(mem_read); endproperty
    a_drop: assert property (p_drop)
        else $error("request and read not released together");
    property p_step;
        mem_read && $past(mem_read) && $changed(mem_addr)
            |-> mem_addr - $past(mem_addr) == ADDR_W'(2);
    endproperty
    a_step: assert property (p_step)
        else $error("burst address not stepping by one word");
    // ====
    // pixel stream framing
    property p_strobe; lcd_pixel_strobe |=> !lcd_pixel_strobe; endproperty
    a_strobe: assert property (p_strobe)
        else $error("pixel strobe wider than one cycle");
    property p_line; lcd_line_pulse |-> lcd_pixel_strobe; endproperty
    a_line: assert property (p_line)
        else $error("line pulse without a pixel");
    property p_frame;
        lcd_frame_mark |-> lcd_pixel_strobe && !lcd_line_pulse;
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame mark not on a first pixel");
endmodule

bind lcdrc_engine lcdrc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### verification/lcdrc_mem_model.sv
// memory and bus arbiter model serving the fly-by screen fetches
`timescale 1ns/10ps
module lcdrc_mem_model
#(
    parameter int ADDR_W = 29
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // fetch bus
    input wire logic bus_request,
    output logic bus_grant,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_read,
    output logic [15:0] mem_rdata,
    // bench controls: slow arbitration, stored word
    input wire logic slow,
    input wire logic [15:0] fill_word
);
    logic [3:0] wait_r;
    // arbitration wait restarts whenever the request is withdrawn
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !bus_request)
            wait_r <= 4'h0;
        else if (wait_r != 4'hF)
            wait_r <= wait_r + 4'h1;
    end
    assign bus_grant = bus_request && (wait_r >= (slow ? 4'h6 : 4'h0));
    // zero wait state data; inverted word, moving only while a grant is awaited
    assign mem_rdata = mem_read ? fill_word : ~fill_word ^ 16'(wait_r);
endmodule

// ### verification/test_lcd_refresh_cursor_grayscale.sv
// self-checking bench for the lcd refresh, cursor and gray engine
`timescale 1ns/10ps
module test_lcd_refresh_cursor_grayscale;
    import lcdrc_pkg::*;
    logic clk_sys, sys_rst, avs_read, avs_write, pixel_clk_in, slow, lp;
    logic avs_waitrequest, bus_request, bus_grant, mem_read, lcd_pixel;
    logic lcd_pixel_strobe, lcd_line_pulse, lcd_frame_mark;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [28:0] mem_addr;
    logic [15:0] mem_rdata, v;
    int n_fail = 0;
    int check_count = 0;
    // ====
    // 50 ns system clock, 400 ns pixel clock of unrelated phase
    initial
    begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        pixel_clk_in = 0;
        #37;
        forever #200 pixel_clk_in = ~pixel_clk_in;
    end
    lcdrc_engine DUT (.clk_en(1'b1), .*);
    lcdrc_mem_model u_mem (.fill_word(16'hA5C3), .*);
    // ====
    // compare, close and bus helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        if (i >= 50)
            late;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic late;
        chk(32'h0, 32'h1);
        test_done;
    endtask
    // first 16 pixels of the next frame, leftmost in bit 15
    task automatic grab;
        int i;
        int n;
        n = 0;
        for (i = 0; i < 20000 && n < 16; i++)
        begin
            @(posedge clk_sys);
            if (lcd_pixel_strobe === 1'b1 && (n > 0 || lcd_frame_mark))
            begin
                v = {v[14:0], lcd_pixel};
                lp = lcd_line_pulse;
                n++;
            end
        end
        if (n < 16)
            late;
    endtask
    // next burst starts at the frame base and reads len cycles
    task automatic burst(input int len);
        int i;
        int k;
        for (i = 0; i < 5000 && bus_request !== 1'b1; i++)
            @(posedge clk_sys);
        if (i >= 5000)
            late;
        chk(32'(mem_addr), 32'h0000_0100);
        k = 0;
        for (i = 0; i < 200 && bus_request === 1'b1; i++)
        begin
            @(posedge clk_sys);
            k += int'(mem_read === 1'b1);
        end
        chk(k, len);
    endtask
    // ====
    // scenarios
    task automatic t_regs;
        logic [5:0] a[9] = '{OFS_START, OFS_WIDTH, OFS_HEIGHT, OFS_CUR_X,
            OFS_CUR_WH, OFS_BLINK, OFS_PALETTE, OFS_FRC, 6'h34};
        logic [31:0] e[9] = '{32'(RST_START), 32'(RST_WIDTH),
            32'(RST_HEIGHT), 32'(RST_CUR_X), 32'(RST_CUR_WH),
            32'(RST_BLINK), 32'(RST_PALETTE), 32'(RST_FRC), 32'h0000_0000};
        bus(1'b1, 6'h34, 32'hFFFF_FFFF);
        foreach (a[i])
        begin
            bus(1'b0, a[i], 32'h0000_0000);
            chk(q, e[i]);
        end
        $display("test regs done");
    endtask
    task automatic t_mono;
        bus(1'b1, OFS_START, 32'h0000_0100);
        bus(1'b1, OFS_WIDTH, 32'h0000_0010);
        bus(1'b1, OFS_HEIGHT, 32'h0000_0001);
        bus(1'b1, OFS_CLOCKING, 32'h0000_0083);
        burst(3);
        grab;
        chk(v, 16'hA5C3);
        chk(lp, 1'b1);
        $display("test mono done");
    endtask
    // cursor over pixels 4..7 of row 0 in black, white and reversed style, then blinking
    task automatic t_cursor;
        logic [1:0] s[3] = '{CUR_BLACK, CUR_WHITE, CUR_INVERT};
        logic [15:0] e[3] = '{16'hAFC3, 16'hA0C3, 16'hAAC3};
        int k;
        bus(1'b1, OFS_CUR_WH, 32'h0000_0401);
        foreach (s[i])
        begin
            bus(1'b1, OFS_CUR_X, {16'h0000, s[i], 14'h0004});
            grab;
            chk(v, e[i]);
        end
        bus(1'b1, OFS_BLINK, 32'h0000_0080);
        bus(1'b1, OFS_CUR_X, 32'h0000_4004);
        grab;
        k = int'(v === 16'hAFC3);
        grab;
        k += int'(v === 16'hAFC3);
        chk(k, 1);
        bus(1'b1, OFS_CUR_X, 32'h0000_0000);
        $display("test cursor done");
    endtask
    task automatic t_gray;
        int on0;
        int both;
        bus(1'b1, OFS_MODE, 32'h0000_0001);
        bus(1'b1, OFS_PALETTE, 32'h0000_F0F0);
        grab;
        grab;
        chk(v, 16'h3939);
        bus(1'b1, OFS_PALETTE, 32'h0000_1111);
        on0 = 0;
        both = 0;
        repeat (16)
        begin
            grab;
            on0 += int'(v[15] === 1'b1);
            both += int'(v[15:14] === 2'b11);
        end
        chk(on0, 2);
        chk(both, 0);
        $display("test gray done");
    endtask
    // stop while running, stay quiet, restart from the frame base
    task automatic t_off;
        int i;
        int quiet;
        bus(1'b1, OFS_CLOCKING, 32'h0000_0003);
        quiet = 0;
        for (i = 0; i < 4000 && quiet < 600; i++)
        begin
            @(posedge clk_sys);
            quiet = (bus_request | lcd_pixel_strobe) === 1'b0 ? quiet + 1 : 0;
        end
        chk(quiet, 600);
        slow <= 1'b1;
        bus(1'b1, OFS_CLOCKING, 32'h0000_0083);
        burst(6);
        $display("test off done");
    endtask
    initial
    begin
        {avs_read, avs_write, avs_address, avs_writedata, slow} = '0;
        sys_rst = 1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_regs;
        t_mono;
        t_cursor;
        t_gray;
        t_off;
        test_done;
    end
endmodule
